// file: tpr_routing_display.sv
// Timing port routing and display control with an AXI4-Lite register slave.
`timescale 1ns/1ns
module tpr_routing_display (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tpr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [tpr_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic remote_mode,
  input wire logic [15:0] motor_stopped,
  input wire logic [15:0] timing_signal,
  input wire logic panel_channel_selector,
  input wire logic [3:0] panel_channel_value,
  input wire logic key_strobe,
  input wire logic [3:0] key_code,
  output logic [3:0] timing_port_out,
  output tpr_pkg::tpr_port_map_t timing_port_channel,
  output logic [3:0] display_channel,
  output logic comment_view
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic remote_s1;
    logic remote_s2;
    logic [15:0] stop_s1;
    logic [15:0] stop_s2;
    logic [15:0] tim_s1;
    logic [15:0] tim_s2;
    logic psel_s1;
    logic psel_s2;
    logic psel_s3;
    logic [3:0] pch_s1;
    logic [3:0] pch_s2;
    logic key_s1;
    logic key_s2;
    logic key_s3;
    logic [3:0] kcode_s1;
    logic [3:0] kcode_s2;
    logic fixed;
    logic view;
    logic [3:0] disp_ch;
    tpr_pkg::tpr_port_map_t route;
    tpr_pkg::tpr_route_res_t last_res;
    logic [tpr_pkg::NUM_CH-1:0][tpr_pkg::CMT_LEN-1:0][7:0] cmt;
    tpr_pkg::tpr_char_class_t cls;
    logic [3:0] cur_ch;
    logic [1:0] cur_pos;
    tpr_pkg::tpr_port_map_t port_ch;
    logic [3:0] tout;
  } tpr_state_t;

  tpr_state_t s;
  tpr_state_t next_s;
  logic [7:0] step_char;
  logic step_forward;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] hex_decode(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (c >= tpr_pkg::CHR_0 && c <= tpr_pkg::CHR_9) begin
      d = c - tpr_pkg::CHR_0;
      return {1'b1, d[3:0]};
    end
    if (c >= tpr_pkg::CHR_UA && c <= tpr_pkg::CHR_UF) begin
      d = c - tpr_pkg::CHR_UA + tpr_pkg::HEX_ALPHA_OFS;
      return {1'b1, d[3:0]};
    end
    if (c >= tpr_pkg::CHR_LA && c <= tpr_pkg::CHR_LF) begin
      d = c - tpr_pkg::CHR_LA + tpr_pkg::HEX_ALPHA_OFS;
      return {1'b1, d[3:0]};
    end
    return 5'h00;
  endfunction

  function automatic logic [7:0] hex_encode(input logic [3:0] v);
    if (v < 4'ha) begin
      return tpr_pkg::CHR_0 + {4'h0, v};
    end
    return tpr_pkg::CHR_UA + {4'h0, v} - tpr_pkg::HEX_ALPHA_OFS;
  endfunction

  // Checks a route command as a whole and returns the map to keep.
  function automatic tpr_pkg::tpr_route_outcome_t apply_route(input logic [31:0] cmd,
      input tpr_pkg::tpr_port_map_t cur, input logic [15:0] stopped, input logic remote);
    tpr_pkg::tpr_route_outcome_t o;
    tpr_pkg::tpr_port_map_t nm;
    logic [4:0] dec;
    logic bad;
    logic dup;
    logic busy;
    nm = cur;
    bad = 1'b0;
    dup = 1'b0;
    busy = 1'b0;
    for (int i = 0; i < tpr_pkg::NUM_PORTS; i++) begin
      if (cmd[8*i +: 8] != tpr_pkg::CHR_DASH) begin
        dec = hex_decode(cmd[8*i +: 8]);
        if (!dec[4]) begin
          bad = 1'b1;
        end else begin
          nm[i] = dec[3:0];
        end
      end
      if (remote && nm[i] != cur[i] && !(stopped[cur[i]] && stopped[nm[i]])) begin
        busy = 1'b1;
      end
    end
    for (int i = 0; i < tpr_pkg::NUM_PORTS; i++) begin
      for (int j = i + 1; j < tpr_pkg::NUM_PORTS; j++) begin
        if (nm[i] == nm[j]) begin
          dup = 1'b1;
        end
      end
    end
    o.map = cur;
    if (bad) begin
      o.res = tpr_pkg::RES_BAD_CHAR;
    end else if (dup) begin
      o.res = tpr_pkg::RES_DUPLICATE;
    end else if (busy) begin
      o.res = tpr_pkg::RES_MOTOR_BUSY;
    end else begin
      o.res = tpr_pkg::RES_OK;
      o.map = nm;
    end
    return o;
  endfunction

  function automatic tpr_state_t reset_state();
    tpr_state_t r;
    r = '0;
    r.cls = tpr_pkg::CLS_UPPER;
    r.last_res = tpr_pkg::RES_OK;
    r.fixed = 1'b0;
    r.view = 1'b0;
    for (int i = 0; i < tpr_pkg::NUM_PORTS; i++) begin
      r.route[i] = 4'(i);
      r.port_ch[i] = 4'(i);
    end
    for (int c = 0; c < tpr_pkg::NUM_CH; c++) begin
      r.cmt[c][0] = tpr_pkg::CHR_UC;
      r.cmt[c][1] = tpr_pkg::CHR_UH;
      r.cmt[c][2] = hex_encode(4'(c));
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Comment character stepping
  // ----------------------------------------------------------------
  assign step_forward = (s.kcode_s2 == 4'h7) || (s.kcode_s2 == 4'h8) || (s.kcode_s2 == 4'h9) ||
                        (s.kcode_s2 == 4'h0);

  tpr_char_step u_step (
    .cls(s.cls),
    .cur_char(s.cmt[s.cur_ch][s.cur_pos]),
    .forward(step_forward),
    .next_char(step_char)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    tpr_pkg::tpr_route_outcome_t ro;
    logic [7:0] wa;
    logic [7:0] ra;
    ro = '0;
    wa = {s.aw_addr[7:2], 2'b00};
    ra = {s_axi_araddr[7:2], 2'b00};
    next_s = s;

    // Pin inputs pass two flip-flops before use.
    next_s.remote_s1 = remote_mode;
    next_s.remote_s2 = s.remote_s1;
    next_s.stop_s1 = motor_stopped;
    next_s.stop_s2 = s.stop_s1;
    next_s.tim_s1 = timing_signal;
    next_s.tim_s2 = s.tim_s1;
    next_s.psel_s1 = panel_channel_selector;
    next_s.psel_s2 = s.psel_s1;
    next_s.psel_s3 = s.psel_s2;
    next_s.pch_s1 = panel_channel_value;
    next_s.pch_s2 = s.pch_s1;
    next_s.key_s1 = key_strobe;
    next_s.key_s2 = s.key_s1;
    next_s.key_s3 = s.key_s2;
    next_s.kcode_s1 = key_code;
    next_s.kcode_s2 = s.kcode_s1;

    // Panel selector switches the display channel in local or fixed mode.
    if (s.psel_s2 && !s.psel_s3 && (!s.remote_s2 || s.fixed)) begin
      next_s.disp_ch = s.pch_s2;
    end

    // Local comment entry at the cursor while the comment view is shown.
    if (s.key_s2 && !s.key_s3 && !s.remote_s2 && s.view) begin
      unique case (s.kcode_s2)
        4'h4: begin
          next_s.cls = tpr_pkg::CLS_UPPER;
          next_s.cmt[s.cur_ch][s.cur_pos] = tpr_pkg::START_UPPER;
        end
        4'h5: begin
          next_s.cls = tpr_pkg::CLS_LOWER;
          next_s.cmt[s.cur_ch][s.cur_pos] = tpr_pkg::START_LOWER;
        end
        4'h6: begin
          next_s.cls = tpr_pkg::CLS_DIGIT;
          next_s.cmt[s.cur_ch][s.cur_pos] = tpr_pkg::START_DIGIT;
        end
        tpr_pkg::KEY_PLUS_MINUS: begin
          next_s.cls = tpr_pkg::CLS_SYMBOL;
          next_s.cmt[s.cur_ch][s.cur_pos] = tpr_pkg::START_SYMBOL;
        end
        4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, tpr_pkg::KEY_CLEAR: begin
          next_s.cmt[s.cur_ch][s.cur_pos] = step_char;
        end
        default: begin
          next_s.cls = s.cls;
        end
      endcase
    end

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = tpr_pkg::RESP_OKAY;
      if (wa == tpr_pkg::ADDR_CTRL) begin
        if (s.wstrb[0] && s.remote_s2 && (&s.stop_s2)) begin
          next_s.fixed = s.wdata[tpr_pkg::CTRL_FIXED_BIT];
        end
        if (s.wstrb[0] && s.remote_s2) begin
          next_s.view = s.wdata[tpr_pkg::CTRL_VIEW_BIT];
        end
      end else if (wa == tpr_pkg::ADDR_ROUTE) begin
        if (s.wstrb == 4'hf) begin
          ro = apply_route(s.wdata, s.route, s.stop_s2, s.remote_s2);
          next_s.route = ro.map;
          next_s.last_res = ro.res;
        end
      end else if (wa == tpr_pkg::ADDR_DISP_CH) begin
        if (s.wstrb[0] && s.remote_s2) begin
          next_s.disp_ch = s.wdata[3:0];
        end
      end else if (wa == tpr_pkg::ADDR_CURSOR) begin
        if (s.wstrb[0] && s.wdata[tpr_pkg::CURSOR_POS_LSB +: 2] != 2'h3) begin
          next_s.cur_ch = s.wdata[tpr_pkg::CURSOR_CH_LSB +: 4];
          next_s.cur_pos = s.wdata[tpr_pkg::CURSOR_POS_LSB +: 2];
        end
      end else begin
        next_s.bresp = tpr_pkg::RESP_SLVERR;
      end
    end

    // Read channel.
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = tpr_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (ra == tpr_pkg::ADDR_CTRL) begin
        next_s.rdata[tpr_pkg::CTRL_FIXED_BIT] = s.fixed;
        next_s.rdata[tpr_pkg::CTRL_VIEW_BIT] = s.view;
      end else if (ra == tpr_pkg::ADDR_ROUTE) begin
        for (int i = 0; i < tpr_pkg::NUM_PORTS; i++) begin
          next_s.rdata[8*i +: 8] = hex_encode(s.route[i]);
        end
      end else if (ra == tpr_pkg::ADDR_DISP_CH) begin
        next_s.rdata[3:0] = s.disp_ch;
      end else if (ra == tpr_pkg::ADDR_CURSOR) begin
        next_s.rdata[tpr_pkg::CURSOR_CH_LSB +: 4] = s.cur_ch;
        next_s.rdata[tpr_pkg::CURSOR_POS_LSB +: 2] = s.cur_pos;
        next_s.rdata[tpr_pkg::CURSOR_CLS_LSB +: 4] = s.cls;
      end else if (ra == tpr_pkg::ADDR_STATUS) begin
        next_s.rdata[tpr_pkg::STATUS_RES_LSB +: 2] = s.last_res;
        next_s.rdata[tpr_pkg::STATUS_REMOTE_BIT] = s.remote_s2;
        next_s.rdata[tpr_pkg::STATUS_STOP_LSB +: 16] = s.stop_s2;
      end else if (ra >= tpr_pkg::ADDR_CMT_BASE && ra <= tpr_pkg::ADDR_CMT_LAST) begin
        next_s.rdata[23:0] = s.cmt[ra[5:2]];
      end else begin
        next_s.rresp = tpr_pkg::RESP_SLVERR;
      end
    end

    // Port routing: fixed map or channels following the display.
    for (int i = 0; i < tpr_pkg::NUM_PORTS; i++) begin
      if (s.fixed) begin
        next_s.port_ch[i] = s.route[i];
      end else begin
        next_s.port_ch[i] = s.disp_ch + 4'(i);
      end
      next_s.tout[i] = s.tim_s2[s.port_ch[i]];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign timing_port_out = s.tout;
  assign timing_port_channel = s.port_ch;
  assign display_channel = s.disp_ch;
  assign comment_view = s.view;

endmodule

// file: tpr_pkg.sv
// Constants and types for the timing port routing and display block.
package tpr_pkg;

  localparam int NUM_PORTS = 4;
  localparam int NUM_CH = 16;
  localparam int CMT_LEN = 3;
  localparam int AXI_ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ROUTE = 8'h04;
  localparam logic [7:0] ADDR_DISP_CH = 8'h08;
  localparam logic [7:0] ADDR_CURSOR = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CMT_BASE = 8'h40;
  localparam logic [7:0] ADDR_CMT_LAST = 8'h7c;

  localparam int CTRL_FIXED_BIT = 1;
  localparam int CTRL_VIEW_BIT = 2;
  localparam int CURSOR_CH_LSB = 0;
  localparam int CURSOR_POS_LSB = 4;
  localparam int CURSOR_CLS_LSB = 6;
  localparam int STATUS_RES_LSB = 0;
  localparam int STATUS_REMOTE_BIT = 2;
  localparam int STATUS_STOP_LSB = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CHR_DASH = 8'h2d;
  localparam logic [7:0] CHR_0 = 8'h30;
  localparam logic [7:0] CHR_9 = 8'h39;
  localparam logic [7:0] CHR_UA = 8'h41;
  localparam logic [7:0] CHR_UF = 8'h46;
  localparam logic [7:0] CHR_UZ = 8'h5a;
  localparam logic [7:0] CHR_LA = 8'h61;
  localparam logic [7:0] CHR_LF = 8'h66;
  localparam logic [7:0] CHR_LZ = 8'h7a;
  localparam logic [7:0] CHR_UC = 8'h43;
  localparam logic [7:0] CHR_UH = 8'h48;
  localparam logic [7:0] HEX_ALPHA_OFS = 8'h0a;
  localparam logic [7:0] START_UPPER = 8'h4d;
  localparam logic [7:0] START_LOWER = 8'h6d;
  localparam logic [7:0] START_DIGIT = 8'h35;
  localparam logic [7:0] START_SYMBOL = 8'h3a;

  localparam int SYM_COUNT = 15;
  localparam logic [SYM_COUNT-1:0][7:0] SYM_TABLE = {
    8'h5f, 8'h5e, 8'h5d, 8'h5c, 8'h5b, 8'h3f, 8'h3e, 8'h3d,
    8'h3c, 8'h3b, 8'h3a, 8'h2f, 8'h2d, 8'h2c, 8'h2b};

  // ----------------------------------------------------------------
  // Keypad codes
  // ----------------------------------------------------------------
  localparam logic [3:0] KEY_PLUS_MINUS = 4'ha;
  localparam logic [3:0] KEY_CLEAR = 4'hb;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CLS_UPPER = 4'h1,
    CLS_LOWER = 4'h2,
    CLS_DIGIT = 4'h4,
    CLS_SYMBOL = 4'h8
  } tpr_char_class_t;

  typedef enum logic [1:0] {
    RES_OK = 2'h0,
    RES_BAD_CHAR = 2'h1,
    RES_DUPLICATE = 2'h2,
    RES_MOTOR_BUSY = 2'h3
  } tpr_route_res_t;

  typedef logic [NUM_PORTS-1:0][3:0] tpr_port_map_t;

  typedef struct packed {
    tpr_route_res_t res;
    tpr_port_map_t map;
  } tpr_route_outcome_t;

endpackage

// file: tpr_char_step.sv
// Steps a comment character one place forward or backward within a character class.
`timescale 1ns/1ns
module tpr_char_step (
  input wire tpr_pkg::tpr_char_class_t cls,
  input wire logic [7:0] cur_char,
  input wire logic forward,
  output logic [7:0] next_char
);

  logic [7:0] lo;
  logic [7:0] hi;
  logic found;
  logic [3:0] idx;

  always_comb begin
    lo = tpr_pkg::CHR_UA;
    hi = tpr_pkg::CHR_UZ;
    found = 1'b0;
    idx = 4'h0;
    next_char = cur_char;
    unique case (cls)
      tpr_pkg::CLS_UPPER: begin
        lo = tpr_pkg::CHR_UA;
        hi = tpr_pkg::CHR_UZ;
      end
      tpr_pkg::CLS_LOWER: begin
        lo = tpr_pkg::CHR_LA;
        hi = tpr_pkg::CHR_LZ;
      end
      tpr_pkg::CLS_DIGIT: begin
        lo = tpr_pkg::CHR_0;
        hi = tpr_pkg::CHR_9;
      end
      tpr_pkg::CLS_SYMBOL: begin
        lo = tpr_pkg::SYM_TABLE[0];
        hi = tpr_pkg::SYM_TABLE[tpr_pkg::SYM_COUNT-1];
      end
      default: begin
        lo = tpr_pkg::CHR_UA;
        hi = tpr_pkg::CHR_UZ;
      end
    endcase
    // One step per press, wrapping at both ends of the class.
    if (cls == tpr_pkg::CLS_SYMBOL) begin
      for (int i = 0; i < tpr_pkg::SYM_COUNT; i++) begin
        if (tpr_pkg::SYM_TABLE[i] == cur_char) begin
          found = 1'b1;
          idx = 4'(i);
        end
      end
      if (!found) begin
        next_char = lo;
      end else if (forward) begin
        next_char = (idx == 4'(tpr_pkg::SYM_COUNT - 1)) ? lo : tpr_pkg::SYM_TABLE[idx + 4'h1];
      end else begin
        next_char = (idx == 4'h0) ? hi : tpr_pkg::SYM_TABLE[idx - 4'h1];
      end
    end else if (cur_char < lo || cur_char > hi) begin
      next_char = lo;
    end else if (forward) begin
      next_char = (cur_char == hi) ? lo : cur_char + 8'h01;
    end else begin
      next_char = (cur_char == lo) ? hi : cur_char - 8'h01;
    end
  end

endmodule

// file: tpr_routing_display_properties.sv
// Concurrent checks on the ports of the routing and display block.
`timescale 1ns/1ns
module tpr_routing_display_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic remote_mode,
  input wire tpr_pkg::tpr_port_map_t timing_port_channel,
  input wire logic [3:0] display_channel,
  input wire logic comment_view
);
  logic [5:0] rem_hist;
  always_ff @(posedge clock) begin
    rem_hist <= {rem_hist[4:0], remote_mode};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  write_answer_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  reset_state_a: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !comment_view &&
    display_channel == 4'h0 && timing_port_channel == 16'h3210) else $error("bad reset state");
  port_unique_a: assert property (timing_port_channel[0] != timing_port_channel[1] &&
    timing_port_channel[0] != timing_port_channel[2] && timing_port_channel[0] != timing_port_channel[3] &&
    timing_port_channel[1] != timing_port_channel[2] && timing_port_channel[1] != timing_port_channel[3] &&
    timing_port_channel[2] != timing_port_channel[3]) else $error("channel on two ports");
  view_remote_a: assert property ($changed(comment_view) |-> |rem_hist) else $error("view changed in local");
endmodule
bind tpr_routing_display tpr_routing_display_properties chk (.clock(clock), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .remote_mode(remote_mode), .timing_port_channel(timing_port_channel),
  .display_channel(display_channel), .comment_view(comment_view));

// file: tpr_motor_model.sv
// Motor side stand-in that presents stop flags and timing signals on the pins.
`timescale 1ns/1ns
module tpr_motor_model (
  input wire logic [15:0] stop_req,
  input wire logic [15:0] ts_req,
  output logic [15:0] motor_stopped,
  output logic [15:0] timing_signal
);
  assign motor_stopped = stop_req;
  assign timing_signal = ts_req;
endmodule

// file: tpr_routing_display_tb.sv
// Self-checking bench for the routing and display block.
`timescale 1ns/1ns
module tpr_routing_display_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0;
  logic remote = 1'b0, panel = 1'b0, key_s = 1'b0;
  logic [3:0] panel_val = 4'h0, key_c = 4'h0;
  logic [15:0] stop_req = 16'hffff, ts_req = 16'h0, ms, ts;
  logic awready, wready, bvalid, arready, rvalid, comment_view;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] timing_port_out, display_channel, d;
  tpr_pkg::tpr_port_map_t timing_port_channel;
  int errors = 0;
  int cmp_count = 0;
  int seed = 72851;
  always #20 clock = ~clock;
  tpr_motor_model motor (.stop_req(stop_req), .ts_req(ts_req), .motor_stopped(ms), .timing_signal(ts));
  tpr_routing_display uut (.clock(clock), .rst_n(rst_n), .s_axi_awvalid(aw_v), .s_axi_awready(awready),
    .s_axi_awaddr(aw_a), .s_axi_wvalid(w_v), .s_axi_wready(wready), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(b_r), .s_axi_bresp(bresp), .s_axi_arvalid(ar_v),
    .s_axi_arready(arready), .s_axi_araddr(ar_a), .s_axi_rvalid(rvalid), .s_axi_rready(r_r),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .remote_mode(remote), .motor_stopped(ms), .timing_signal(ts),
    .panel_channel_selector(panel), .panel_channel_value(panel_val), .key_strobe(key_s), .key_code(key_c),
    .timing_port_out(timing_port_out), .timing_port_channel(timing_port_channel),
    .display_channel(display_channel), .comment_view(comment_view));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clock);
    aw_v <= 1'b1;
    aw_a <= a;
    w_v <= 1'b1;
    w_d <= dat;
    b_r <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (aw_v && awready) aw_v <= 1'b0;
      if (w_v && wready) w_v <= 1'b0;
      if (bvalid) begin
        b_r <= 1'b0;
        check(bresp, er);
        done = 1'b1;
      end
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clock);
    ar_v <= 1'b1;
    ar_a <= a;
    r_r <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (ar_v && arready) ar_v <= 1'b0;
      if (rvalid) begin
        r_r <= 1'b0;
        check(rdata, exp);
        check(rresp, er);
        done = 1'b1;
      end
    end
  endtask
  task automatic key(input logic [3:0] c, input int n);
    repeat (n) begin
      key_c <= c;
      key_s <= 1'b1;
      repeat (4) @(posedge clock);
      key_s <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  task automatic port_chk(input logic [15:0] map);
    ts_req <= 16'($random(seed));
    repeat (8) @(posedge clock);
    for (int i = 0; i < 4; i++) check(timing_port_out[i], ts_req[map[4*i+:4]]);
    check(timing_port_channel, map);
  endtask
  function automatic logic [31:0] st(input logic [15:0] stop, input logic [1:0] res);
    st = {stop, 13'h0, 1'b1, res};
  endfunction
  function automatic logic [15:0] lmap(input logic [3:0] c);
    lmap = {c + 4'h3, c + 4'h2, c + 4'h1, c};
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check(comment_view, 1'b0);
    rdchk(tpr_pkg::ADDR_CTRL, 32'h0, tpr_pkg::RESP_OKAY);
    rdchk(tpr_pkg::ADDR_ROUTE, 32'h33323130, tpr_pkg::RESP_OKAY);
    rdchk(tpr_pkg::ADDR_CMT_BASE + 8'h04, 32'h00314843, tpr_pkg::RESP_OKAY);
    port_chk(16'h3210);
    remote <= 1'b1;
    wr(tpr_pkg::ADDR_ROUTE, 32'h46433834, tpr_pkg::RESP_OKAY);
    port_chk(16'h3210);
    wr(tpr_pkg::ADDR_CTRL, 32'h2, tpr_pkg::RESP_OKAY);
    port_chk(16'hfc84);
    rdchk(tpr_pkg::ADDR_ROUTE, 32'h46433834, tpr_pkg::RESP_OKAY);
    wr(tpr_pkg::ADDR_ROUTE, 32'h2d2d2d61, tpr_pkg::RESP_OKAY);
    port_chk(16'hfc8a);
    wr(tpr_pkg::ADDR_ROUTE, 32'h2d2d2d38, tpr_pkg::RESP_OKAY);
    rdchk(tpr_pkg::ADDR_STATUS, st(16'hffff, 2'h2), tpr_pkg::RESP_OKAY);
    wr(tpr_pkg::ADDR_ROUTE, 32'h2d2d2d47, tpr_pkg::RESP_OKAY);
    rdchk(tpr_pkg::ADDR_STATUS, st(16'hffff, 2'h1), tpr_pkg::RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      stop_req <= (k == 1) ? 16'hfbff : 16'hfffd;
      repeat (4) @(posedge clock);
      wr(tpr_pkg::ADDR_ROUTE, 32'h2d2d2d31, tpr_pkg::RESP_OKAY);
      rdchk(tpr_pkg::ADDR_STATUS, st(stop_req, 2'h3), tpr_pkg::RESP_OKAY);
      port_chk(16'hfc8a);
    end
    stop_req <= 16'hffff;
    wr(tpr_pkg::ADDR_ROUTE, 32'h2d2d2d31, tpr_pkg::RESP_OKAY);
    port_chk(16'hfc81);
    panel_val <= 4'h9;
    panel <= 1'b1;
    repeat (4) @(posedge clock);
    panel <= 1'b0;
    repeat (4) @(posedge clock);
    check(display_channel, 4'h9);
    wr(tpr_pkg::ADDR_CTRL, 32'h0, tpr_pkg::RESP_OKAY);
    repeat (4) begin
      d = 4'($random(seed));
      wr(tpr_pkg::ADDR_DISP_CH, {28'h0, d}, tpr_pkg::RESP_OKAY);
      port_chk(lmap(d));
    end
    rdchk(8'h20, 32'h0, tpr_pkg::RESP_SLVERR);
    wr(tpr_pkg::ADDR_STATUS, 32'h0, tpr_pkg::RESP_SLVERR);
    wr(tpr_pkg::ADDR_CTRL, 32'h4, tpr_pkg::RESP_OKAY);
    wr(tpr_pkg::ADDR_CURSOR, 32'h1, tpr_pkg::RESP_OKAY);
    remote <= 1'b0;
    wr(tpr_pkg::ADDR_CTRL, 32'h0, tpr_pkg::RESP_OKAY);
    check(comment_view, 1'b1);
    key(4'h4, 1);
    rdchk(tpr_pkg::ADDR_CMT_BASE + 8'h04, 32'h0031484d, tpr_pkg::RESP_OKAY);
    key(4'h1, 13);
    rdchk(tpr_pkg::ADDR_CMT_BASE + 8'h04, 32'h0031485a, tpr_pkg::RESP_OKAY);
    key(4'h7, 1);
    wr(tpr_pkg::ADDR_CURSOR, 32'h11, tpr_pkg::RESP_OKAY);
    key(4'ha, 1);
    key(4'hb, 2);
    wr(tpr_pkg::ADDR_CURSOR, 32'h21, tpr_pkg::RESP_OKAY);
    key(4'h6, 1);
    key(4'h9, 1);
    rdchk(tpr_pkg::ADDR_CMT_BASE + 8'h04, 32'h00362d41, tpr_pkg::RESP_OKAY);
    rdchk(tpr_pkg::ADDR_CURSOR, 32'h121, tpr_pkg::RESP_OKAY);
    wr(tpr_pkg::ADDR_CURSOR, 32'h2, tpr_pkg::RESP_OKAY);
    key(4'h5, 1);
    key(4'h0, 1);
    rdchk(tpr_pkg::ADDR_CMT_BASE + 8'h08, 32'h0032486e, tpr_pkg::RESP_OKAY);
    results;
  end
  initial begin
    #2000000;
    errors++;
    results;
  end
endmodule
